/* File: hdl/ccie_pkg.sv */
// Package: register map, field layout, reset values and types of the command/irq-enable block
package ccie_pkg;
  localparam int ADDR_W = 12;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_COMMAND = 10'h0D1;
  localparam logic [9:0] IDX_COMM_EN = 10'h0D2;
  localparam logic [9:0] IDX_MISC_EN = 10'h0D3;
  localparam logic [9:0] IDX_COMM_FLAG = 10'h0D4;
  localparam logic [9:0] IDX_MISC_FLAG = 10'h0D5;
  // Command register fields
  localparam int CMD_RCV_OFF_BIT = 5;
  localparam int CMD_SLEEP_BIT = 4;
  localparam int CMD_CODE_LSB = 0;
  localparam logic [3:0] CMD_IDLE = 4'h0;
  localparam logic [3:0] CMD_SOFT_RESTART = 4'hF;
  localparam logic [15:0] CMD_VALID_MASK = 16'hB18F;
  // Flag write polarity bit in both flag registers
  localparam int FLAG_POL_BIT = 7;
  // Common flag/enable bit positions
  localparam int COMM_TX = 6;
  localparam int COMM_RX = 5;
  localparam int COMM_IDLE = 4;
  localparam int COMM_HI = 3;
  localparam int COMM_LO = 2;
  localparam int COMM_ERR = 1;
  localparam int COMM_TIMER = 0;
  // Misc flag/enable bit positions
  localparam int MISC_SIG = 4;
  localparam int MISC_MODE = 3;
  localparam int MISC_CRC = 2;
  localparam int MISC_FON = 1;
  localparam int MISC_FOFF = 0;
  // Routing of common flags onto the two lines; misc flags all go to line zero
  localparam logic [6:0] COMM_LINE1_MASK = 7'h6C;
  localparam logic [6:0] COMM_LINE0_MASK = 7'h13;
  localparam logic [4:0] MISC_LINE0_MASK = 5'h1F;
  // Reset values
  localparam logic [3:0] RST_CMD = 4'h0;
  localparam logic RST_RCV_OFF = 1'b1;
  localparam logic [6:0] RST_COMM_EN = 7'h00;
  localparam logic [4:0] RST_MISC_EN = 5'h00;
  localparam logic [6:0] RST_COMM_FLAG = 7'h14;
  localparam logic [4:0] RST_MISC_FLAG = 5'h00;
  // Wake-up phase after leaving low power
  localparam int CLK_PERIOD_PS = 5000;
  localparam int WAKE_TIME_NS = 1000;
  localparam int WAKE_CYCLES = (WAKE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WAKE_CNT_W = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PWR_AWAKE = 2'h0,
    PWR_SLEEP = 2'h1,
    PWR_WAKING = 2'h3
  } ccie_pwr_t;

  typedef struct packed {
    logic tx_done;
    logic rx_end;
    logic high_alert;
    logic low_alert;
    logic error;
    logic timer_expiry;
    logic mode_detected;
    logic checksum_done;
    logic field_appeared;
    logic field_lost;
    logic command_done;
  } ccie_event_t;

  typedef struct packed {
    logic [3:0] cmd;
    logic rcv_off;
    ccie_pwr_t pwr;
    logic [WAKE_CNT_W-1:0] wake_cnt;
    logic start;
    logic [6:0] en_comm;
    logic [4:0] en_misc;
    logic [6:0] fl_comm;
    logic [4:0] fl_misc;
    logic irq0;
    logic irq1;
    logic sig_s1;
    logic sig_s2;
    logic sig_d;
    logic aw_ok;
    logic w_ok;
    logic [ADDR_W-1:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } ccie_state_t;
endpackage : ccie_pkg

/* File: hdl/ccie_top.sv */
// Command register, interrupt enables, request flags and AXI4-Lite slave
// What this block does
// R1: Receiver-off bit 5 of command register powers down the receiver analog part.
// R2: Writing sleep bit 4 as one enters low power; field detector stays on.
// R3: Clearing sleep starts wake-up; bit reads one until the unit is ready.
// R4: Setting sleep is ignored while the soft restart command is active.
// R5: Writing the four-bit command field launches the command with that code.
// R6: Reading the command field returns the command currently executing.
// R7: Common enable bit 6 routes transmit-done flag onto line one.
// R8: Common enable bit 5 routes receive-end flag onto line one.
// R9: Common enable bit 4 routes idle flag onto line zero.
// R10: Common enable bit 3 routes high-alert flag onto line one.
// R11: Common enable bit 2 routes low-alert flag onto line one.
// R12: Common enable bit 1 routes error flag onto line zero.
// R13: Common enable bit 0 routes timer-expiry flag onto line zero.
// R14: Misc enable bit 4 routes secure-signal-activity flag onto line zero.
// R15: Misc enable bit 3 routes mode-detected flag onto line zero.
// R16: Misc enable bit 2 routes checksum-done flag onto line zero.
// R17: Misc enable bit 1 routes field-appeared flag onto line zero.
// R18: Misc enable bit 0 routes field-lost flag onto line zero.
// R19: Command field is also updated internally, returning to idle when execution ends.
// R20: An unknown command code reverts to idle and sets the idle flag.
// R21: Flag writes: selected bits take the value of write bit 7, others keep.
// R22: Each line is high while any enabled flag routed to it is set.
// R23: Reserved bits read zero and ignore writes.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module ccie_top #(
  parameter int WAKE_CYCLES = ccie_pkg::WAKE_CYCLES,
  parameter logic [15:0] VALID_CMDS = ccie_pkg::CMD_VALID_MASK
) (
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  input wire logic [ccie_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [ccie_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire ccie_pkg::ccie_event_t EVENTS_I,
  input wire logic SECURE_SIGNAL_INPUT_I,
  output logic [3:0] COMMAND_CODE_O,
  output logic COMMAND_START_O,
  output logic RECEIVER_ANALOG_OFF_O,
  output logic ANALOG_SLEEP_O,
  output logic IRQ_LINE_ZERO_O,
  output logic IRQ_LINE_ONE_O
);
  logic [1:0] rst_sync;
  logic rst_n;
  ccie_pkg::ccie_state_t s;
  ccie_pkg::ccie_state_t next_s;
  logic aw_rdy;
  logic w_rdy;
  logic ar_rdy;
  logic [9:0] w_idx;
  logic [9:0] r_idx;
  logic w_hit;
  logic r_hit;
  logic idle_set;
  logic soft_active;
  logic sig_edge;
  logic [6:0] comm_ev;
  logic [4:0] misc_ev;
  logic [7:0] rd_val;
  logic [6:0] comm_wr;
  logic [4:0] misc_wr;

  // Counter load for the wake-up phase; the sleep bit keeps reading one until it runs out
  localparam logic [ccie_pkg::WAKE_CNT_W-1:0] WAKE_CNT_LOAD =
    ccie_pkg::WAKE_CNT_W'(WAKE_CYCLES - 1);

  // Reset release passes two flops so every flop leaves reset on the same edge
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // A write is held until both address and data are in; no new beat meanwhile
  assign aw_rdy = !s.aw_ok && !s.bvalid;
  assign w_rdy = !s.w_ok && !s.bvalid;
  assign ar_rdy = !s.rvalid;
  assign w_idx = s.awaddr[ccie_pkg::ADDR_W-1:2];
  assign r_idx = S_AXI_ARADDR_I[ccie_pkg::ADDR_W-1:2];
  assign w_hit = (w_idx >= ccie_pkg::IDX_COMMAND) && (w_idx <= ccie_pkg::IDX_MISC_FLAG);
  assign r_hit = (r_idx >= ccie_pkg::IDX_COMMAND) && (r_idx <= ccie_pkg::IDX_MISC_FLAG);
  assign sig_edge = s.sig_s2 ^ s.sig_d;

  // Event inputs come from logic on this clock; only the pin is synchronised
  assign comm_ev = {EVENTS_I.tx_done, EVENTS_I.rx_end, idle_set, EVENTS_I.high_alert,
                    EVENTS_I.low_alert, EVENTS_I.error, EVENTS_I.timer_expiry};
  assign misc_ev = {sig_edge, EVENTS_I.mode_detected, EVENTS_I.checksum_done,
                    EVENTS_I.field_appeared, EVENTS_I.field_lost};

  // Polarity bit selects set or clear for every bit written as one
  always_comb begin
    comm_wr = s.fl_comm;
    misc_wr = s.fl_misc;
    if (s.aw_ok && s.w_ok && s.wstrb0) begin
      if (w_idx == ccie_pkg::IDX_COMM_FLAG) begin
        for (int i = 0; i < 7; i++) begin
          if (s.wdata[i]) begin
            comm_wr[i] = s.wdata[ccie_pkg::FLAG_POL_BIT]; // [R21]
          end
        end
      end
      if (w_idx == ccie_pkg::IDX_MISC_FLAG) begin
        for (int i = 0; i < 5; i++) begin
          if (s.wdata[i]) begin
            misc_wr[i] = s.wdata[ccie_pkg::FLAG_POL_BIT]; // [R21]
          end
        end
      end
    end
  end

  always_comb begin
    rd_val = 8'h00;
    unique case (r_idx)
      ccie_pkg::IDX_COMMAND: begin
        rd_val[ccie_pkg::CMD_RCV_OFF_BIT] = s.rcv_off;
        rd_val[ccie_pkg::CMD_SLEEP_BIT] = (s.pwr != ccie_pkg::PWR_AWAKE); // [R3]
        rd_val[3:0] = s.cmd; // [R6]
      end
      ccie_pkg::IDX_COMM_EN: rd_val = {1'b0, s.en_comm}; // [R23]
      ccie_pkg::IDX_MISC_EN: rd_val = {3'h0, s.en_misc}; // [R23]
      ccie_pkg::IDX_COMM_FLAG: rd_val = {1'b0, s.fl_comm};
      ccie_pkg::IDX_MISC_FLAG: rd_val = {3'h0, s.fl_misc};
      default: rd_val = 8'h00;
    endcase
  end

  always_comb begin
    next_s = s;
    idle_set = 1'b0;
    soft_active = (s.cmd == ccie_pkg::CMD_SOFT_RESTART);
    next_s.start = 1'b0;
    next_s.sig_s1 = SECURE_SIGNAL_INPUT_I;
    next_s.sig_s2 = s.sig_s1;
    next_s.sig_d = s.sig_s2;
    if (S_AXI_AWVALID_I && aw_rdy) begin
      next_s.aw_ok = 1'b1;
      next_s.awaddr = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && w_rdy) begin
      next_s.w_ok = 1'b1;
      next_s.wdata = S_AXI_WDATA_I[7:0];
      next_s.wstrb0 = S_AXI_WSTRB_I[0];
    end
    if (S_AXI_BREADY_I && s.bvalid) begin
      next_s.bvalid = 1'b0;
    end
    // Executor reports the end of a running command
    if (EVENTS_I.command_done && (s.cmd != ccie_pkg::CMD_IDLE)) begin
      next_s.cmd = ccie_pkg::CMD_IDLE; // [R19]
      idle_set = 1'b1;
    end
    if (s.pwr == ccie_pkg::PWR_WAKING) begin
      if (s.wake_cnt == '0) begin
        next_s.pwr = ccie_pkg::PWR_AWAKE; // [R3]
      end else begin
        next_s.wake_cnt = s.wake_cnt - 1'b1;
      end
    end
    if (s.aw_ok && s.w_ok) begin
      next_s.aw_ok = 1'b0;
      next_s.w_ok = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = w_hit ? ccie_pkg::RESP_OKAY : ccie_pkg::RESP_SLVERR;
      if (s.wstrb0) begin
        unique case (w_idx)
          ccie_pkg::IDX_COMMAND: begin
            next_s.rcv_off = s.wdata[ccie_pkg::CMD_RCV_OFF_BIT]; // [R1]
            // A software write overrides a completion seen in the same cycle
            if (VALID_CMDS[s.wdata[3:0]]) begin
              next_s.cmd = s.wdata[3:0]; // [R5]
              next_s.start = (s.wdata[3:0] != ccie_pkg::CMD_IDLE); // [R5]
              idle_set = 1'b0;
            end else begin
              next_s.cmd = ccie_pkg::CMD_IDLE; // [R20]
              idle_set = 1'b1; // [R20]
            end
            soft_active = soft_active || (s.wdata[3:0] == ccie_pkg::CMD_SOFT_RESTART);
            if (s.wdata[ccie_pkg::CMD_SLEEP_BIT]) begin
              if (!soft_active) begin
                next_s.pwr = ccie_pkg::PWR_SLEEP; // [R2] [R4]
              end
            end else if (s.pwr == ccie_pkg::PWR_SLEEP) begin
              next_s.pwr = ccie_pkg::PWR_WAKING; // [R3]
              next_s.wake_cnt = WAKE_CNT_LOAD;
            end
          end
          ccie_pkg::IDX_COMM_EN: next_s.en_comm = s.wdata[6:0]; // [R23]
          ccie_pkg::IDX_MISC_EN: next_s.en_misc = s.wdata[4:0]; // [R23]
          default: begin
          end
        endcase
      end
    end
    if (S_AXI_ARVALID_I && ar_rdy) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_val;
      next_s.rresp = r_hit ? ccie_pkg::RESP_OKAY : ccie_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY_I && s.rvalid) begin
      next_s.rvalid = 1'b0;
    end
    // Hardware set wins over a software clear in the same cycle
    next_s.fl_comm = comm_wr | comm_ev; // [R21]
    next_s.fl_misc = misc_wr | misc_ev; // [R21]
    // [R7] [R8] [R10] [R11] line one; [R9] [R12] [R13] line zero
    next_s.irq1 = |(next_s.fl_comm & next_s.en_comm & ccie_pkg::COMM_LINE1_MASK); // [R22]
    // [R14] [R15] [R16] [R17] [R18] misc flags all on line zero
    next_s.irq0 = (|(next_s.fl_comm & next_s.en_comm & ccie_pkg::COMM_LINE0_MASK)) ||
                  (|(next_s.fl_misc & next_s.en_misc & ccie_pkg::MISC_LINE0_MASK)); // [R22]
  end

  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.cmd <= ccie_pkg::RST_CMD;
      s.rcv_off <= ccie_pkg::RST_RCV_OFF;
      s.pwr <= ccie_pkg::PWR_AWAKE;
      s.en_comm <= ccie_pkg::RST_COMM_EN;
      s.en_misc <= ccie_pkg::RST_MISC_EN;
      s.fl_comm <= ccie_pkg::RST_COMM_FLAG;
      s.fl_misc <= ccie_pkg::RST_MISC_FLAG;
    end else begin
      s <= next_s;
    end
  end

  assign S_AXI_AWREADY_O = aw_rdy;
  assign S_AXI_WREADY_O = w_rdy;
  assign S_AXI_BVALID_O = s.bvalid;
  assign S_AXI_BRESP_O = s.bresp;
  assign S_AXI_ARREADY_O = ar_rdy;
  assign S_AXI_RVALID_O = s.rvalid;
  assign S_AXI_RDATA_O = {24'h000000, s.rdata};
  assign S_AXI_RRESP_O = s.rresp;
  assign COMMAND_CODE_O = s.cmd;
  assign COMMAND_START_O = s.start;
  assign RECEIVER_ANALOG_OFF_O = s.rcv_off; // [R1]
  // Only the sleep state switches analog off; the field detector is not gated here
  assign ANALOG_SLEEP_O = (s.pwr == ccie_pkg::PWR_SLEEP); // [R2]
  assign IRQ_LINE_ZERO_O = s.irq0;
  assign IRQ_LINE_ONE_O = s.irq1;
endmodule : ccie_top

/* File: testbench/ccie_chk.sv */
// Checker: register-bus handshake and command output assertions
`timescale 1ns/1ps
module ccie_chk (
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_WREADY_O,
  input wire logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire ccie_pkg::ccie_event_t EVENTS_I,
  input wire logic [3:0] COMMAND_CODE_O,
  input wire logic COMMAND_START_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);
  chk_bresp_held: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
    |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O)) else $error("write response dropped");
  chk_rdata_held: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
    |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O)) else $error("read data dropped");
  chk_write_refused: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
    else $error("write taken while response pending");
  chk_read_refused: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
    else $error("read taken while data pending");
  chk_upper_zero: assert property (
    S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:8] == 24'h0) else $error("upper read bytes not zero");
  chk_start_code: assert property (
    COMMAND_START_O |-> COMMAND_CODE_O != 4'h0) else $error("start with idle code");
  chk_start_pulse: assert property (
    COMMAND_START_O |=> !COMMAND_START_O) else $error("start longer than one cycle");
  chk_done_idle: assert property (
    EVENTS_I.command_done && COMMAND_CODE_O != 4'h0 && !COMMAND_START_O
    |=> COMMAND_CODE_O == 4'h0) else $error("command field kept after finish");
endmodule : ccie_chk
bind ccie_top ccie_chk ccie_chk_i (.CLOCK_I, .RESETN_I, .S_AXI_AWREADY_O, .S_AXI_WREADY_O,
  .S_AXI_BRESP_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I, .S_AXI_ARREADY_O, .S_AXI_RDATA_O,
  .S_AXI_RVALID_O, .S_AXI_RREADY_I, .EVENTS_I, .COMMAND_CODE_O, .COMMAND_START_O);

/* File: testbench/ccie_exec_model.sv */
// Behavioural command executor: reports each started command finished after a delay
`timescale 1ns/1ps
module ccie_exec_model (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic slow_i,
  output logic done_o
);
  int cnt = 0;
  // Slow mode keeps the command visible long enough to be read back
  always @(posedge clk_i) begin
    done_o <= (cnt == 1);
    if (start_i) cnt <= slow_i ? 12 : 2;
    else if (cnt != 0) cnt <= cnt - 1;
  end
endmodule : ccie_exec_model

/* File: testbench/tb_top.sv */
// Testbench: register accesses, command flow, power states and interrupt routing
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, pin = 0, slow = 0, e1;
  logic [11:0] awa = 0, ara = 0, ad;
  logic [31:0] wd = 0, got;
  logic [9:0] evv = 0;
  logic [1:0] rs, bs;
  wire awr, wrr, bv, arr, rv, st, l0, l1, so, sl, dn;
  wire [1:0] bresp, rresp;
  wire [31:0] rdat;
  wire [3:0] code;
  wire ccie_pkg::ccie_event_t ev = ccie_pkg::ccie_event_t'({evv, dn});
  int failures = 0, tests_run = 0, i, b;
  initial forever #2.5 clk = ~clk;
  ccie_top #(.WAKE_CYCLES(20)) ccie_top_i (.CLOCK_I(clk), .RESETN_I(rst_n),
    .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
    .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrr), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
    .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv),
    .S_AXI_RREADY_I(rr), .EVENTS_I(ev), .SECURE_SIGNAL_INPUT_I(pin), .COMMAND_CODE_O(code),
    .COMMAND_START_O(st), .RECEIVER_ANALOG_OFF_O(so), .ANALOG_SLEEP_O(sl),
    .IRQ_LINE_ZERO_O(l0), .IRQ_LINE_ONE_O(l1));
  ccie_exec_model ccie_exec_model_i (.clk_i(clk), .start_i(st), .slow_i(slow), .done_o(dn));
  task close_out;
    if (failures == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task tmo(input int n);
    if (n >= 40) begin
      chk("bus wait", 1, 0);
      close_out;
    end
  endtask : tmo
  // Signals sampled right after the edge still hold their pre-edge values
  task wr(input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1;
    wv <= 1;
    br <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awv && awr) awv <= 0;
      if (wv && wrr) wv <= 0;
      if (bv) begin
        bs = bresp;
        break;
      end
    end
    br <= 0;
    tmo(n);
  endtask : wr
  task rd(input logic [11:0] a);
    int n;
    @(posedge clk);
    ara <= a;
    arv <= 1;
    rr <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arv && arr) arv <= 0;
      if (rv) begin
        got = rdat;
        rs = rresp;
        break;
      end
    end
    rr <= 0;
    tmo(n);
  endtask : rd
  task rc(input logic [11:0] a, input logic [7:0] e);
    rd(a);
    chk($sformatf("reg %h", a), {24'h0, e}, got);
  endtask : rc
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    rc(12'h344, 8'h20);
    rc(12'h348, 8'h00);
    rc(12'h34C, 8'h00);
    rc(12'h350, 8'h14);
    rc(12'h354, 8'h00);
    chk("receiver off", 1, so);
    rd(12'h358);
    chk("unmapped resp", 2, rs);
    wr(12'h358, 8'hFF);
    chk("unmapped bresp", 2, bs);
    wr(12'h348, 8'hFF);
    chk("write resp", 0, bs);
    rc(12'h348, 8'h7F);
    wr(12'h34C, 8'hFF);
    rc(12'h34C, 8'h1F);
    wr(12'h344, 8'hC0);
    rc(12'h344, 8'h00);
    chk("receiver off", 0, so);
    wr(12'h348, 8'h00);
    wr(12'h34C, 8'h00);
    wr(12'h350, 8'h14);
    rc(12'h350, 8'h00);
    wr(12'h350, 8'h84);
    rc(12'h350, 8'h04);
    slow <= 1;
    wr(12'h344, 8'h21);
    rc(12'h344, 8'h21);
    chk("code out", 4'h1, code);
    repeat (15) @(posedge clk);
    rc(12'h344, 8'h20);
    rc(12'h350, 8'h14);
    wr(12'h350, 8'h7F);
    wr(12'h344, 8'h24);
    rc(12'h344, 8'h20);
    rc(12'h350, 8'h10);
    wr(12'h344, 8'h3F);
    rc(12'h344, 8'h2F);
    chk("code out", 4'hF, code);
    slow <= 0;
    repeat (15) @(posedge clk);
    wr(12'h344, 8'h28);
    repeat (8) @(posedge clk);
    rc(12'h344, 8'h20);
    wr(12'h344, 8'h30);
    chk("sleep out", 1, sl);
    rc(12'h344, 8'h30);
    wr(12'h344, 8'h20);
    chk("sleep out", 0, sl);
    rc(12'h344, 8'h30);
    repeat (25) @(posedge clk);
    rc(12'h344, 8'h20);
    for (i = 0; i < 12; i++) begin
      b = (i < 7) ? i : i - 7;
      ad = (i < 7) ? 12'h350 : 12'h354;
      e1 = (i < 7) && (((8'h6C >> b) & 8'h01) != 8'h00);
      wr(ad, 8'h7F);
      wr(ad - 12'h8, 8'h01 << b);
      wr(ad, 8'h80 | (8'h01 << b));
      chk("line one", e1, l1);
      chk("line zero", !e1, l0);
      wr(ad - 12'h8, 8'h00);
      chk("lines masked", 0, {l1, l0});
    end
    wr(12'h350, 8'h7F);
    wr(12'h348, 8'h40);
    evv[9] <= 1;
    @(posedge clk);
    evv[9] <= 0;
    @(posedge clk);
    chk("line one event", 1, l1);
    wr(12'h354, 8'h1F);
    pin <= 1;
    repeat (6) @(posedge clk);
    rc(12'h354, 8'h10);
    close_out;
  end
endmodule : tb_top
